/* common/cbs_pkg.sv */
// shared constants and types for the charger boost/system control register block
package cbs_pkg;
	// register pointers on the serial host port
	localparam logic [7:0] CBS_ADDR_ADAPTIVE = 8'h3c;
	localparam logic [7:0] CBS_ADDR_BOOST = 8'h3d;
	localparam logic [7:0] CBS_ADDR_SYS = 8'h3e;
	// reset values
	localparam logic [7:0] CBS_RST_ADAPTIVE = 8'h0c;
	localparam logic [7:0] CBS_RST_BOOST = 8'h20;
	localparam logic [7:0] CBS_RST_SYS = 8'h36;
	localparam logic [7:0] CBS_READ_UNMAPPED = 8'h00;
	// field positions, reverse boost control
	localparam int CBS_BOOST_ON_BIT = 0;
	localparam int CBS_FORCE_FF_BIT = 4;
	localparam int CBS_RAMP_LSB = 5;
	localparam int CBS_RAMP_W = 3;
	// field positions, system charge control
	localparam int CBS_MINSYS_LSB = 0;
	localparam int CBS_MINSYS_W = 3;
	localparam int CBS_MANUAL_SW_BIT = 3;
	localparam int CBS_CHARGE_ON_BIT = 4;
	localparam int CBS_PRECHG_LSB = 5;
	localparam int CBS_PRECHG_W = 2;
	localparam int CBS_LIMIT_SRC_BIT = 7;
	// field position, adaptive input control
	localparam int CBS_ADAPT_LSB = 1;
	localparam int CBS_ADAPT_W = 4;
	// decoded values, millivolts and milliamps
	localparam logic [12:0] CBS_ADAPT_BASE_MV = 13'h0f3c;
	localparam logic [12:0] CBS_ADAPT_STEP_MV = 13'h0064;
	localparam logic [3:0] CBS_ADAPT_TOP_CODE = 4'h9;
	localparam logic [12:0] CBS_ADAPT_MAX_MV = 13'h12c0;
	localparam logic [12:0] CBS_MINSYS_BASE_MV = 13'h0bb8;
	localparam logic [12:0] CBS_MINSYS_STEP_MV = 13'h0064;
	localparam logic [2:0] CBS_MINSYS_TOP_CODE = 3'h7;
	localparam logic [12:0] CBS_MINSYS_TOP_MV = 13'h0fa0;
	localparam logic [8:0] CBS_PRECHG_STEP_MA = 9'h064;
	localparam logic [8:0] CBS_USB_LOW_MA = 9'h064;
	localparam logic [8:0] CBS_USB_HIGH_MA = 9'h1f4;
	localparam logic [8:0] CBS_LIMIT_NONE_MA = 9'h000;
	// timing: slow tick derived from the system clock
	localparam int CBS_SYS_CLK_PERIOD_NS = 20;
	localparam int CBS_SLOW_TICK_PERIOD_NS = 10000;
	localparam int CBS_SLOW_TICK_CYCLES = CBS_SLOW_TICK_PERIOD_NS / CBS_SYS_CLK_PERIOD_NS;
	localparam int CBS_PERIOD_W = 7;
	// serial host port
	localparam logic [2:0] CBS_BIT_LAST = 3'h7;
	typedef enum logic [3:0] {
		CBS_ST_IDLE,
		CBS_ST_ADDR,
		CBS_ST_ADDR_ACK,
		CBS_ST_PTR,
		CBS_ST_PTR_ACK,
		CBS_ST_WR,
		CBS_ST_WR_ACK,
		CBS_ST_RD,
		CBS_ST_RD_ACK
	} cbs_host_state_e;
endpackage : cbs_pkg

/* design/cbs_boost_ramp.sv */
// boost output voltage target slew limiter on the slow tick
`timescale 1ns/100ps
module cbs_boost_ramp
	import cbs_pkg::*;
#(
	parameter int CODE_W = 8,
	parameter int TICK_CYCLES = CBS_SLOW_TICK_CYCLES
) (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rstn,
	// control
	input wire logic [CBS_RAMP_W-1:0] i_ramp_speed,
	input wire logic [CODE_W-1:0] i_target_code,
	// ramped target
	output logic [CODE_W-1:0] o_applied_code
);
	localparam int TW = $clog2(TICK_CYCLES);
	localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

	logic [TW-1:0] tick_cnt_q;
	logic slow_tick;
	logic [CBS_PERIOD_W-1:0] per_cnt_q;
	logic [CBS_PERIOD_W-1:0] per_last;
	logic [CODE_W-1:0] applied_q;

	// free-running slow tick, one pulse per tick period
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			tick_cnt_q <= '0;
		end else if (tick_cnt_q == TICK_LAST) begin
			tick_cnt_q <= '0;
		end else begin
			tick_cnt_q <= tick_cnt_q + 1'b1;
		end
	end
	assign slow_tick = (tick_cnt_q == TICK_LAST);

	// code n waits 2^(n-1) ticks per step
	assign per_last = (CBS_PERIOD_W'(1) << (i_ramp_speed - 1'b1)) - 1'b1;

	// step one code toward the target; a zero speed bypasses the ramp
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			applied_q <= '0;
			per_cnt_q <= '0;
		end else if (i_ramp_speed == '0) begin
			applied_q <= i_target_code;
			per_cnt_q <= '0;
		end else if (applied_q == i_target_code) begin
			per_cnt_q <= '0;
		end else if (slow_tick) begin
			if (per_cnt_q == per_last) begin
				per_cnt_q <= '0;
				// one 25 mV code per step, either direction
				if (applied_q < i_target_code) begin
					applied_q <= applied_q + 1'b1;
				end else begin
					applied_q <= applied_q - 1'b1;
				end
			end else begin
				per_cnt_q <= per_cnt_q + 1'b1;
			end
		end
	end
	assign o_applied_code = applied_q;
endmodule : cbs_boost_ramp

/* design/cbs_ctrl_regs.sv */
// charger boost and system control registers behind the serial host port
`timescale 1ns/100ps
module cbs_ctrl_regs
	import cbs_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = 7'h5a, // arbitrary bus address
	parameter int CODE_W = 8,
	parameter int TICK_CYCLES = CBS_SLOW_TICK_CYCLES
) (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rstn,
	// serial host port, open-drain data
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda,
	output logic o_sda_oe,
	// charger core status
	input wire logic i_charger_write_lock_open,
	input wire logic i_hw_battery_phase,
	input wire logic i_usb_high_limit_sel,
	input wire logic [5:0] i_input_limit_code,
	input wire logic [CODE_W-1:0] i_boost_target_code,
	// reverse boost controls
	output logic o_reverse_boost_on,
	output logic o_boost_force_fixed_freq,
	output logic [CODE_W-1:0] o_boost_applied_code,
	// system and charge controls
	output logic [12:0] o_min_sys_voltage_mv,
	output logic o_battery_path_switch,
	output logic o_charge_on,
	output logic [8:0] o_precharge_ma,
	output logic o_input_limit_by_code,
	output logic [5:0] o_input_limit_code,
	output logic [8:0] o_usb_limit_ma,
	output logic [12:0] o_adaptive_threshold_mv
);
	logic scl_s1_q, scl_s2_q, scl_s3_q;
	logic sda_s1_q, sda_s2_q, sda_s3_q;
	logic scl_rise, scl_fall, start_seen, stop_seen;
	cbs_host_state_e state_q;
	logic [2:0] bit_cnt_q;
	logic [7:0] shift_q;
	logic [7:0] ptr_q;
	logic rd_mode_q, nack_q, sda_oe_q;
	logic byte_full_q;
	logic wr_stb_q;
	logic [7:0] wr_addr_q, wr_data_q;
	logic [7:0] adaptive_ctl_q, boost_ctl_q, sys_ctl_q;
	logic [CBS_ADAPT_W-1:0] adapt_code;
	logic [CBS_MINSYS_W-1:0] minsys_code;
	logic [CBS_PRECHG_W-1:0] prechg_code;
	logic [12:0] adapt_mv_q, minsys_mv_q;
	logic [8:0] prechg_ma_q, usb_ma_q;
	logic switch_q, by_code_q;
	logic [5:0] limit_code_q;

	// register readback; no read clears or changes anything
	function automatic logic [7:0] read_reg(input logic [7:0] ptr);
		logic [7:0] val;
		val = CBS_READ_UNMAPPED;
		if (ptr == CBS_ADDR_ADAPTIVE) begin
			val = adaptive_ctl_q;
		end else if (ptr == CBS_ADDR_BOOST) begin
			val = boost_ctl_q;
		end else if (ptr == CBS_ADDR_SYS) begin
			val = sys_ctl_q;
		end
		return val;
	endfunction : read_reg

	// adaptive threshold code to millivolts, clamped at the top
	function automatic logic [12:0] adapt_to_mv(input logic [CBS_ADAPT_W-1:0] code);
		logic [12:0] mv;
		mv = CBS_ADAPT_MAX_MV;
		if (code <= CBS_ADAPT_TOP_CODE) begin
			mv = CBS_ADAPT_BASE_MV + CBS_ADAPT_STEP_MV * 13'(code);
		end
		return mv;
	endfunction : adapt_to_mv

	// minimum system code to millivolts; the top code jumps to 4.0 V
	function automatic logic [12:0] minsys_to_mv(input logic [CBS_MINSYS_W-1:0] code);
		logic [12:0] mv;
		mv = CBS_MINSYS_TOP_MV;
		if (code != CBS_MINSYS_TOP_CODE) begin
			mv = CBS_MINSYS_BASE_MV + CBS_MINSYS_STEP_MV * 13'(code);
		end
		return mv;
	endfunction : minsys_to_mv

	// two-flop synchronisers, third stage only for edge detection
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			scl_s1_q <= 1'b1;
			scl_s2_q <= 1'b1;
			scl_s3_q <= 1'b1;
			sda_s1_q <= 1'b1;
			sda_s2_q <= 1'b1;
			sda_s3_q <= 1'b1;
		end else begin
			scl_s1_q <= i_scl;
			scl_s2_q <= scl_s1_q;
			scl_s3_q <= scl_s2_q;
			sda_s1_q <= i_sda;
			sda_s2_q <= sda_s1_q;
			sda_s3_q <= sda_s2_q;
		end
	end

	// bus conditions seen on synchronised lines
	assign scl_rise = scl_s2_q && !scl_s3_q;
	assign scl_fall = !scl_s2_q && scl_s3_q;
	assign start_seen = scl_s2_q && scl_s3_q && sda_s3_q && !sda_s2_q;
	assign stop_seen = scl_s2_q && scl_s3_q && !sda_s3_q && sda_s2_q;

	// host port sequencer: bits are sampled on clock rise, moved on clock fall
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			state_q <= CBS_ST_IDLE;
			bit_cnt_q <= '0;
			shift_q <= '0;
			ptr_q <= '0;
			rd_mode_q <= 1'b0;
			nack_q <= 1'b0;
			byte_full_q <= 1'b0;
			wr_stb_q <= 1'b0;
			wr_addr_q <= '0;
			wr_data_q <= '0;
		end else begin
			wr_stb_q <= 1'b0;
			if (start_seen) begin
				state_q <= CBS_ST_ADDR; // repeated start also lands here
				bit_cnt_q <= '0;
				byte_full_q <= 1'b0;
			end else if (stop_seen) begin
				state_q <= CBS_ST_IDLE;
			end else if (scl_rise) begin
				if (state_q == CBS_ST_ADDR || state_q == CBS_ST_PTR || state_q == CBS_ST_WR) begin
					// receive bits count on the rise so the fall that ends a start is ignored
					shift_q <= {shift_q[6:0], sda_s2_q};
					bit_cnt_q <= bit_cnt_q + 1'b1;
					byte_full_q <= (bit_cnt_q == CBS_BIT_LAST);
				end else if (state_q == CBS_ST_RD_ACK) begin
					nack_q <= sda_s2_q;
				end
			end else if (scl_fall) begin
				case (state_q)
					CBS_ST_ADDR: begin
						if (byte_full_q) begin
							byte_full_q <= 1'b0;
							rd_mode_q <= shift_q[0];
							state_q <= (shift_q[7:1] == DEV_ADDR) ? CBS_ST_ADDR_ACK : CBS_ST_IDLE;
						end
					end
					CBS_ST_ADDR_ACK: begin
						if (rd_mode_q) begin
							state_q <= CBS_ST_RD;
							shift_q <= read_reg(ptr_q);
						end else begin
							state_q <= CBS_ST_PTR;
						end
					end
					CBS_ST_PTR: begin
						if (byte_full_q) begin
							byte_full_q <= 1'b0;
							state_q <= CBS_ST_PTR_ACK;
							ptr_q <= shift_q;
						end
					end
					CBS_ST_PTR_ACK: begin
						state_q <= CBS_ST_WR;
					end
					CBS_ST_WR: begin
						if (byte_full_q) begin
							byte_full_q <= 1'b0;
							state_q <= CBS_ST_WR_ACK;
							wr_stb_q <= 1'b1;
							wr_addr_q <= ptr_q;
							wr_data_q <= shift_q;
						end
					end
					CBS_ST_WR_ACK: begin
						state_q <= CBS_ST_WR;
						ptr_q <= ptr_q + 1'b1; // burst writes walk upward
					end
					CBS_ST_RD: begin
						bit_cnt_q <= bit_cnt_q + 1'b1;
						if (bit_cnt_q == CBS_BIT_LAST) begin
							state_q <= CBS_ST_RD_ACK;
							ptr_q <= ptr_q + 1'b1;
						end else begin
							shift_q <= {shift_q[6:0], 1'b0};
						end
					end
					CBS_ST_RD_ACK: begin
						if (nack_q) begin
							state_q <= CBS_ST_IDLE;
						end else begin
							state_q <= CBS_ST_RD;
							shift_q <= read_reg(ptr_q);
						end
					end
					default: begin
						state_q <= CBS_ST_IDLE;
					end
				endcase
			end
		end
	end

	// data pull-down: acknowledges and zero read bits; lags the fall by one cycle
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			sda_oe_q <= 1'b0;
		end else begin
			sda_oe_q <= (state_q == CBS_ST_ADDR_ACK) || (state_q == CBS_ST_PTR_ACK) ||
				(state_q == CBS_ST_WR_ACK) || (state_q == CBS_ST_RD && !shift_q[7]);
		end
	end
	assign o_sda_oe = sda_oe_q;
	assign o_sda = 1'b0; // open drain only ever pulls low

	// reverse boost control: never locked, reserved bits stored as written
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			boost_ctl_q <= CBS_RST_BOOST;
		end else if (wr_stb_q && wr_addr_q == CBS_ADDR_BOOST) begin
			boost_ctl_q <= wr_data_q;
		end
	end

	// system control: writes dropped while the write lock is closed
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			sys_ctl_q <= CBS_RST_SYS;
		end else if (wr_stb_q && wr_addr_q == CBS_ADDR_SYS && i_charger_write_lock_open) begin
			sys_ctl_q <= wr_data_q;
		end
	end

	// adaptive input control shares the same lock
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			adaptive_ctl_q <= CBS_RST_ADAPTIVE;
		end else if (wr_stb_q && wr_addr_q == CBS_ADDR_ADAPTIVE && i_charger_write_lock_open) begin
			adaptive_ctl_q <= wr_data_q;
		end
	end

	// field extraction
	assign adapt_code = adaptive_ctl_q[CBS_ADAPT_LSB +: CBS_ADAPT_W];
	assign minsys_code = sys_ctl_q[CBS_MINSYS_LSB +: CBS_MINSYS_W];
	assign prechg_code = sys_ctl_q[CBS_PRECHG_LSB +: CBS_PRECHG_W];

	// decoded analog targets, registered so the outputs never glitch
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			adapt_mv_q <= CBS_ADAPT_MAX_MV;
			minsys_mv_q <= CBS_MINSYS_TOP_MV;
			prechg_ma_q <= CBS_PRECHG_STEP_MA;
		end else begin
			adapt_mv_q <= adapt_to_mv(adapt_code);
			minsys_mv_q <= minsys_to_mv(minsys_code);
			prechg_ma_q <= CBS_PRECHG_STEP_MA * (9'(prechg_code) + 9'h001);
		end
	end

	// battery path switch: hardware phase or software override
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			switch_q <= 1'b0;
		end else begin
			switch_q <= sys_ctl_q[CBS_MANUAL_SW_BIT] || i_hw_battery_phase;
		end
	end

	// input current limit source
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			by_code_q <= 1'b0;
			limit_code_q <= '0;
			usb_ma_q <= CBS_USB_LOW_MA;
		end else begin
			by_code_q <= sys_ctl_q[CBS_LIMIT_SRC_BIT];
			limit_code_q <= i_input_limit_code;
			if (sys_ctl_q[CBS_LIMIT_SRC_BIT]) begin
				usb_ma_q <= CBS_LIMIT_NONE_MA;
			end else begin
				usb_ma_q <= i_usb_high_limit_sel ? CBS_USB_HIGH_MA : CBS_USB_LOW_MA;
			end
		end
	end

	// boost output target ramp
	cbs_boost_ramp #(
		.CODE_W(CODE_W),
		.TICK_CYCLES(TICK_CYCLES)
	) u_ramp (
		.i_clk_sys(i_clk_sys),
		.i_rstn(i_rstn),
		.i_ramp_speed(boost_ctl_q[CBS_RAMP_LSB +: CBS_RAMP_W]),
		.i_target_code(i_boost_target_code),
		.o_applied_code(o_boost_applied_code)
	);

	// outputs
	assign o_reverse_boost_on = boost_ctl_q[CBS_BOOST_ON_BIT];
	assign o_boost_force_fixed_freq = boost_ctl_q[CBS_FORCE_FF_BIT];
	assign o_charge_on = sys_ctl_q[CBS_CHARGE_ON_BIT];
	assign o_adaptive_threshold_mv = adapt_mv_q;
	assign o_min_sys_voltage_mv = minsys_mv_q;
	assign o_precharge_ma = prechg_ma_q;
	assign o_battery_path_switch = switch_q;
	assign o_input_limit_by_code = by_code_q;
	assign o_input_limit_code = limit_code_q;
	assign o_usb_limit_ma = usb_ma_q;

	// checks
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rstn);

	chk_adapt_low_range: assert property (
		(adapt_code <= CBS_ADAPT_TOP_CODE) |=> (o_adaptive_threshold_mv ==
			CBS_ADAPT_BASE_MV + CBS_ADAPT_STEP_MV * 13'($past(adapt_code))))
		else $error("adaptive threshold decode wrong");
	chk_adapt_clamp_top: assert property (
		(adapt_code > CBS_ADAPT_TOP_CODE) |=> (o_adaptive_threshold_mv == CBS_ADAPT_MAX_MV))
		else $error("adaptive threshold not clamped");
	chk_boost_on_write: assert property (
		(wr_stb_q && wr_addr_q == CBS_ADDR_BOOST) |=>
			(o_reverse_boost_on == $past(wr_data_q[CBS_BOOST_ON_BIT])))
		else $error("boost enable not taken from write");
	chk_force_ff_write: assert property (
		(wr_stb_q && wr_addr_q == CBS_ADDR_BOOST) |=>
			(o_boost_force_fixed_freq == $past(wr_data_q[CBS_FORCE_FF_BIT])))
		else $error("fixed frequency force not taken from write");
	chk_ramp_bypass_now: assert property (
		(boost_ctl_q[CBS_RAMP_LSB +: CBS_RAMP_W] == '0) |=>
			(o_boost_applied_code == $past(i_boost_target_code)))
		else $error("bypass did not apply target at once");
	chk_ramp_one_step: assert property (
		(boost_ctl_q[CBS_RAMP_LSB +: CBS_RAMP_W] != '0) ##1
			(boost_ctl_q[CBS_RAMP_LSB +: CBS_RAMP_W] != '0) |->
			(o_boost_applied_code == $past(o_boost_applied_code)) ||
			(o_boost_applied_code == $past(o_boost_applied_code) + 1'b1) ||
			(o_boost_applied_code == $past(o_boost_applied_code) - 1'b1))
		else $error("ramp moved more than one code");
	chk_minsys_top_code: assert property (
		(minsys_code == CBS_MINSYS_TOP_CODE) |=> (o_min_sys_voltage_mv == CBS_MINSYS_TOP_MV))
		else $error("top system code not 4.0 V");
	chk_path_switch_on: assert property (
		(sys_ctl_q[CBS_MANUAL_SW_BIT] || i_hw_battery_phase) |=> o_battery_path_switch)
		else $error("battery path switch not on");
	chk_sys_lock_hold: assert property (
		(wr_stb_q && wr_addr_q == CBS_ADDR_SYS && !i_charger_write_lock_open) |=>
			$stable(sys_ctl_q))
		else $error("locked system write changed register");
	chk_usb_limit_sel: assert property (
		!sys_ctl_q[CBS_LIMIT_SRC_BIT] |=>
			(o_usb_limit_ma == ($past(i_usb_high_limit_sel) ? CBS_USB_HIGH_MA : CBS_USB_LOW_MA)))
		else $error("usb input limit wrong");

	// main scenarios
	cov_boost_write: cover property (wr_stb_q && wr_addr_q == CBS_ADDR_BOOST);
	cov_locked_write: cover property (wr_stb_q && wr_addr_q == CBS_ADDR_SYS &&
		!i_charger_write_lock_open);
	cov_read_ack: cover property (state_q == CBS_ST_RD_ACK && scl_fall && !nack_q);
	cov_ramp_move: cover property ((boost_ctl_q[CBS_RAMP_LSB +: CBS_RAMP_W] != '0) &&
		(o_boost_applied_code != $past(o_boost_applied_code)));
endmodule : cbs_ctrl_regs

/* bench/cbs_ctrl_regs_bench.sv */
// self-checking bench for the charger boost and system control registers
`timescale 1ns/100ps
module cbs_ctrl_regs_bench;
	import cbs_pkg::*;
	localparam logic [6:0] ADDR = 7'h5a; // arbitrary bus address
	localparam int TICK = 4;
	logic i_clk_sys = 1'b0;
	logic i_rstn = 1'b0;
	logic scl = 1'b1;
	logic m_sda = 1'b1;
	logic lock_open = 1'b1;
	logic hw_phase = 1'b0;
	logic usb_sel = 1'b0;
	logic [5:0] lim_code = 6'h00;
	logic [7:0] tgt = 8'h00;
	logic o_sda;
	logic o_sda_oe;
	logic boost_on;
	logic force_ff;
	logic path_sw;
	logic charge_on;
	logic by_code;
	logic [7:0] applied;
	logic [12:0] minsys_mv;
	logic [12:0] adapt_mv;
	logic [8:0] prechg_ma;
	logic [8:0] usb_ma;
	logic [5:0] lim_out;
	wire logic sda_pin;
	int miscompares = 0;
	int samples_checked = 0;
	int cyc = 0;

	// open-drain data line: either party may pull it low
	assign sda_pin = m_sda & (o_sda_oe ? o_sda : 1'b1);

	cbs_ctrl_regs #(.DEV_ADDR(ADDR), .CODE_W(8), .TICK_CYCLES(TICK)) u_cbs_ctrl_regs (
		.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_scl(scl), .i_sda(sda_pin),
		.o_sda(o_sda), .o_sda_oe(o_sda_oe), .i_charger_write_lock_open(lock_open),
		.i_hw_battery_phase(hw_phase), .i_usb_high_limit_sel(usb_sel),
		.i_input_limit_code(lim_code), .i_boost_target_code(tgt),
		.o_reverse_boost_on(boost_on), .o_boost_force_fixed_freq(force_ff),
		.o_boost_applied_code(applied), .o_min_sys_voltage_mv(minsys_mv),
		.o_battery_path_switch(path_sw), .o_charge_on(charge_on), .o_precharge_ma(prechg_ma),
		.o_input_limit_by_code(by_code), .o_input_limit_code(lim_out),
		.o_usb_limit_ma(usb_ma), .o_adaptive_threshold_mv(adapt_mv));

	// 50 MHz system clock
	initial begin
		forever #10 i_clk_sys = ~i_clk_sys;
	end

	task automatic tk(input int n);
		repeat (n) @(posedge i_clk_sys);
	endtask : tk

	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	// one serial bit; data moves mid-low so it never changes near the clock fall
	task automatic clk_bit(input logic d);
		scl <= 1'b0;
		tk(5);
		m_sda <= d;
		tk(5);
		scl <= 1'b1;
		tk(10);
	endtask : clk_bit

	task automatic start();
		clk_bit(1'b1);
		m_sda <= 1'b0;
		tk(10);
	endtask : start

	task automatic stop();
		clk_bit(1'b0);
		m_sda <= 1'b1;
		tk(10);
	endtask : stop

	task automatic send(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			clk_bit(b[i]);
		end
		clk_bit(1'b1);
		chk("ack", 16'h0001, {15'h0, o_sda_oe});
	endtask : send

	// master nacks the only byte it reads
	task automatic recv(output logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			clk_bit(1'b1);
			b[i] = sda_pin;
		end
		clk_bit(1'b1);
	endtask : recv

	task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
		start();
		send({ADDR, 1'b0});
		send(ptr);
		send(d);
		stop();
		tk(5);
	endtask : wr

	task automatic rd(input logic [7:0] ptr, output logic [7:0] d);
		start();
		send({ADDR, 1'b0});
		send(ptr);
		start();
		send({ADDR, 1'b1});
		recv(d);
		stop();
	endtask : rd

	task automatic t_reset();
		logic [7:0] d;
		chk("boost_on", 16'h0000, {15'h0, boost_on});
		chk("charge_on", 16'h0001, {15'h0, charge_on});
		chk("adapt_mv", 16'h1194, {3'h0, adapt_mv});
		rd(CBS_ADDR_BOOST, d);
		chk("boost_reg", 16'h0020, {8'h0, d});
		rd(CBS_ADDR_SYS, d);
		chk("sys_reg", 16'h0036, {8'h0, d});
		rd(8'h50, d);
		chk("unmapped", 16'h0000, {8'h0, d});
		$display("test reset done");
	endtask : t_reset

	task automatic t_boost();
		logic [7:0] d;
		wr(CBS_ADDR_BOOST, 8'h11);
		chk("boost_on", 16'h0001, {15'h0, boost_on});
		chk("force_ff", 16'h0001, {15'h0, force_ff});
		tgt <= 8'h40;
		tk(3);
		chk("applied", 16'h0040, {8'h0, applied});
		rd(CBS_ADDR_BOOST, d);
		chk("boost_reg", 16'h0011, {8'h0, d});
		wr(CBS_ADDR_BOOST, 8'h00);
		chk("boost_on", 16'h0000, {15'h0, boost_on});
		chk("force_ff", 16'h0000, {15'h0, force_ff});
		$display("test boost done");
	endtask : t_boost

	// speed 3 is one code per four ticks, sixteen clocks with the short tick
	task automatic t_ramp();
		int n;
		wr(CBS_ADDR_BOOST, 8'h60);
		tgt <= 8'h44;
		tk(32);
		n = 32;
		chk("ramp_mid", 16'h0001, {15'h0, applied > 8'h40 && applied < 8'h44});
		while (applied !== 8'h44 && n < 200) begin
			tk(1);
			n++;
		end
		chk("ramp_time", 16'h0001, {15'h0, n >= 48 && n <= 72});
		$display("test ramp done");
	endtask : t_ramp

	task automatic t_sys();
		logic [2:0] c;
		for (int i = 0; i < 8; i++) begin
			c = 3'(i);
			wr(CBS_ADDR_SYS, {1'b0, c[1:0], 1'b1, 1'b0, c});
			chk("minsys_mv", 16'(i == 7 ? 4000 : 3000 + 100 * i), {3'h0, minsys_mv});
			chk("prechg_ma", 16'(100 * (i % 4 + 1)), {7'h0, prechg_ma});
		end
		$display("test sys done");
	endtask : t_sys

	task automatic t_switch();
		wr(CBS_ADDR_SYS, 8'h18);
		chk("path_sw", 16'h0001, {15'h0, path_sw});
		wr(CBS_ADDR_SYS, 8'h00);
		chk("path_sw", 16'h0000, {15'h0, path_sw});
		chk("charge_on", 16'h0000, {15'h0, charge_on});
		hw_phase <= 1'b1;
		tk(3);
		chk("path_sw", 16'h0001, {15'h0, path_sw});
		hw_phase <= 1'b0;
		tk(3);
		chk("path_sw", 16'h0000, {15'h0, path_sw});
		$display("test switch done");
	endtask : t_switch

	task automatic t_limit();
		wr(CBS_ADDR_SYS, 8'h10);
		usb_sel <= 1'b0;
		tk(3);
		chk("usb_ma", 16'h0064, {7'h0, usb_ma});
		chk("by_code", 16'h0000, {15'h0, by_code});
		usb_sel <= 1'b1;
		tk(3);
		chk("usb_ma", 16'h01f4, {7'h0, usb_ma});
		wr(CBS_ADDR_SYS, 8'h90);
		lim_code <= 6'h2a;
		tk(3);
		chk("by_code", 16'h0001, {15'h0, by_code});
		chk("lim_out", 16'h002a, {10'h0, lim_out});
		chk("usb_ma", 16'h0000, {7'h0, usb_ma});
		$display("test limit done");
	endtask : t_limit

	// a closed lock must leave both protected registers untouched
	task automatic t_lock();
		logic [7:0] d;
		lock_open <= 1'b0;
		wr(CBS_ADDR_SYS, 8'h00);
		rd(CBS_ADDR_SYS, d);
		chk("sys_reg", 16'h0090, {8'h0, d});
		chk("charge_on", 16'h0001, {15'h0, charge_on});
		wr(CBS_ADDR_ADAPTIVE, 8'h00);
		chk("adapt_mv", 16'h1194, {3'h0, adapt_mv});
		lock_open <= 1'b1;
		$display("test lock done");
	endtask : t_lock

	task automatic t_adapt();
		logic [3:0] c;
		for (int i = 0; i < 16; i++) begin
			c = 4'(i);
			wr(CBS_ADDR_ADAPTIVE, {3'h0, c, 1'b0});
			chk("adapt_mv", 16'(i >= 9 ? 4800 : 3900 + 100 * i), {3'h0, adapt_mv});
		end
		$display("test adapt done");
	endtask : t_adapt

	task automatic close_out();
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : close_out

	// hang guard, well above the roughly twenty-four thousand cycles the tests take
	always @(posedge i_clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			miscompares++;
			close_out();
		end
	end

	// main sequence
	initial begin
		tk(5);
		i_rstn <= 1'b1;
		tk(5);
		t_reset();
		t_boost();
		t_ramp();
		t_sys();
		t_switch();
		t_limit();
		t_lock();
		t_adapt();
		close_out();
	end
endmodule : cbs_ctrl_regs_bench
